/* File: dtm_fall_det.sv */
`timescale 1ns/1ps
module dtm_fall_det
    import dtm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pin,
    output logic fall
);
    typedef struct packed {
        logic smp;
        logic fall;
    } dtm_fall_st_t;

    dtm_fall_st_t st_ff;
    dtm_fall_st_t nxt_st;

    // pin is synchronous to core_clk, so one sample stage is enough
    always_comb begin
        nxt_st = st_ff;
        nxt_st.smp = pin;
        nxt_st.fall = st_ff.smp & ~pin;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fall = st_ff.fall;

    a_fall_pulse: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(pin) |=> fall)
        else $error("falling edge on input not counted");

endmodule // dtm_fall_det

/* File: dtm_pin_model.sv */
`timescale 1ns/1ps
module dtm_pin_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic gate_req_first,
    input wire logic gate_req_second,
    input wire logic evt_req_first,
    input wire logic evt_req_second,
    output logic ext_irq_pin_first,
    output logic ext_irq_pin_second,
    output logic event_input_first,
    output logic event_input_second
);
    // pins move only just after an edge and hold a full cycle, so each
    // level is seen at least once before it changes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_irq_pin_first <= 1'b0;
            ext_irq_pin_second <= 1'b0;
            // idle high: the event pins sit behind pull-ups
            event_input_first <= 1'b1;
            event_input_second <= 1'b1;
        end else begin
            ext_irq_pin_first <= gate_req_first;
            ext_irq_pin_second <= gate_req_second;
            // one toggle a cycle: high one cycle, low the next
            if (evt_req_first) begin
                event_input_first <= ~event_input_first;
            end
            if (evt_req_second) begin
                event_input_second <= ~event_input_second;
            end
        end
    end
endmodule // dtm_pin_model

/* File: dtm_pkg.sv */
package dtm_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_CNT_LO_FIRST = 8'h8A;
    localparam logic [7:0] IDX_CNT_LO_SECOND = 8'h8B;
    localparam logic [7:0] IDX_CNT_HI_FIRST = 8'h8C;
    localparam logic [7:0] IDX_CNT_HI_SECOND = 8'h8D;
    localparam logic [7:0] IDX_INT_STATUS = 8'h90;
    localparam logic [7:0] IDX_INT_ENABLE = 8'h91;
    localparam logic [7:0] IDX_INT_CLEAR = 8'h92;

    // timer_pair_control fields
    localparam int unsigned CTL_OVF_SECOND = 7;
    localparam int unsigned CTL_RUN_SECOND = 6;
    localparam int unsigned CTL_OVF_FIRST = 5;
    localparam int unsigned CTL_RUN_FIRST = 4;

    // timer_pair_mode fields
    localparam int unsigned MOD_GATE_SECOND = 7;
    localparam int unsigned MOD_SRC_SECOND = 6;
    localparam int unsigned MOD_SEL_LOW_SECOND = 4;
    localparam int unsigned MOD_GATE_FIRST = 3;
    localparam int unsigned MOD_SRC_FIRST = 2;
    localparam int unsigned MOD_SEL_LOW_FIRST = 0;

    // interrupt status, enable and clear fields
    localparam int unsigned INT_FIRST = 0;
    localparam int unsigned INT_SECOND = 1;

    localparam logic [1:0] MODE_PRESCALE = 2'h0;
    localparam logic [1:0] MODE_FULL = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    localparam logic [4:0] PRESC_MAX = 5'h1F;
    localparam logic [7:0] BYTE_MAX = 8'hFF;

    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [1:0] RST_INT = 2'h0;

    function automatic logic dtm_idx_hit(input logic [11:0] addr,
                                         input logic [7:0] idx);
        return (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) &&
               (addr[9:2] == idx);
    endfunction

endpackage

/* File: dtm_timer_pair.sv */
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module dtm_timer_pair
    import dtm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_pin_first,
    input wire logic ext_irq_pin_second,
    input wire logic event_input_first,
    input wire logic event_input_second,
    input wire logic vec_ack_first,
    input wire logic vec_ack_second,
    output logic irq,
    output logic overflow_flag_first,
    output logic overflow_flag_second
);
    typedef struct packed {
        logic [7:0] mode;
        logic run_second;
        logic run_first;
        logic ovf_second;
        logic ovf_first;
        logic [1:0] int_status;
        logic [1:0] int_enable;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } dtm_top_st_t;

    dtm_top_st_t st_ff;
    dtm_top_st_t nxt_st;

    logic acc_first;
    logic acc_done;
    logic wr_en;
    logic mapped;
    logic split_first;
    logic fall_first;
    logic fall_second;
    logic wr_lo_first;
    logic wr_hi_first;
    logic wr_lo_second;
    logic wr_hi_second;
    logic [7:0] lo_first;
    logic [7:0] hi_first;
    logic [7:0] lo_second;
    logic [7:0] hi_second;
    logic ovf_evt_first;
    logic ovf_evt_second;
    logic ovf_evt_split;
    logic evt_first;
    logic evt_second;
    logic [31:0] rd_val;

    // pready is registered, so every transfer has exactly one wait state
    assign acc_first = psel & penable & ~st_ff.pready;
    assign acc_done = psel & penable & st_ff.pready;
    assign wr_en = acc_done & pwrite & pstrb[0];
    assign split_first =
        (st_ff.mode[MOD_SEL_LOW_FIRST +: 2] == MODE_SPLIT);

    assign mapped = dtm_idx_hit(paddr, IDX_CTRL) |
                    dtm_idx_hit(paddr, IDX_MODE) |
                    dtm_idx_hit(paddr, IDX_CNT_LO_FIRST) |
                    dtm_idx_hit(paddr, IDX_CNT_LO_SECOND) |
                    dtm_idx_hit(paddr, IDX_CNT_HI_FIRST) |
                    dtm_idx_hit(paddr, IDX_CNT_HI_SECOND) |
                    dtm_idx_hit(paddr, IDX_INT_STATUS) |
                    dtm_idx_hit(paddr, IDX_INT_ENABLE) |
                    dtm_idx_hit(paddr, IDX_INT_CLEAR);

    assign wr_lo_first = wr_en & dtm_idx_hit(paddr, IDX_CNT_LO_FIRST);
    assign wr_hi_first = wr_en & dtm_idx_hit(paddr, IDX_CNT_HI_FIRST);
    assign wr_lo_second = wr_en & dtm_idx_hit(paddr, IDX_CNT_LO_SECOND);
    assign wr_hi_second = wr_en & dtm_idx_hit(paddr, IDX_CNT_HI_SECOND);

    // in split mode the first timer's high byte owns the second flag
    assign evt_first = ovf_evt_first;
    assign evt_second = split_first ? ovf_evt_split : ovf_evt_second;

    dtm_fall_det u_fall_first (
        .core_clk(core_clk),
        .rst(rst),
        .pin(event_input_first),
        .fall(fall_first)
    );

    dtm_fall_det u_fall_second (
        .core_clk(core_clk),
        .rst(rst),
        .pin(event_input_second),
        .fall(fall_second)
    );

    dtm_timer_unit #(
        .HAS_SPLIT(1'b1)
    ) u_timer_first (
        .core_clk(core_clk),
        .rst(rst),
        .mode_sel(st_ff.mode[MOD_SEL_LOW_FIRST +: 2]),
        .count_src(st_ff.mode[MOD_SRC_FIRST]),
        .gate(st_ff.mode[MOD_GATE_FIRST]),
        .run(st_ff.run_first),
        .ext_irq_pin(ext_irq_pin_first),
        .event_fall(fall_first),
        .split_run(st_ff.run_second),
        .wr_lo(wr_lo_first),
        .wr_hi(wr_hi_first),
        .wdata(pwdata[7:0]),
        .count_lo(lo_first),
        .count_hi(hi_first),
        .ovf(ovf_evt_first),
        .ovf_hi(ovf_evt_split)
    );

    dtm_timer_unit #(
        .HAS_SPLIT(1'b0)
    ) u_timer_second (
        .core_clk(core_clk),
        .rst(rst),
        .mode_sel(st_ff.mode[MOD_SEL_LOW_SECOND +: 2]),
        .count_src(st_ff.mode[MOD_SRC_SECOND]),
        .gate(st_ff.mode[MOD_GATE_SECOND]),
        .run(st_ff.run_second),
        .ext_irq_pin(ext_irq_pin_second),
        .event_fall(fall_second),
        .split_run(1'b0),
        .wr_lo(wr_lo_second),
        .wr_hi(wr_hi_second),
        .wdata(pwdata[7:0]),
        .count_lo(lo_second),
        .count_hi(hi_second),
        .ovf(ovf_evt_second),
        .ovf_hi()
    );

    always_comb begin
        rd_val = 32'h0000_0000;
        if (dtm_idx_hit(paddr, IDX_CTRL)) begin
            rd_val[CTL_OVF_SECOND] = st_ff.ovf_second;
            rd_val[CTL_RUN_SECOND] = st_ff.run_second;
            rd_val[CTL_OVF_FIRST] = st_ff.ovf_first;
            rd_val[CTL_RUN_FIRST] = st_ff.run_first;
        end else if (dtm_idx_hit(paddr, IDX_MODE)) begin
            rd_val[7:0] = st_ff.mode;
        end else if (dtm_idx_hit(paddr, IDX_CNT_LO_FIRST)) begin
            rd_val[7:0] = lo_first;
        end else if (dtm_idx_hit(paddr, IDX_CNT_LO_SECOND)) begin
            rd_val[7:0] = lo_second;
        end else if (dtm_idx_hit(paddr, IDX_CNT_HI_FIRST)) begin
            rd_val[7:0] = hi_first;
        end else if (dtm_idx_hit(paddr, IDX_CNT_HI_SECOND)) begin
            rd_val[7:0] = hi_second;
        end else if (dtm_idx_hit(paddr, IDX_INT_STATUS)) begin
            rd_val[1:0] = st_ff.int_status;
        end else if (dtm_idx_hit(paddr, IDX_INT_ENABLE)) begin
            rd_val[1:0] = st_ff.int_enable;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        if (acc_first) begin
            nxt_st.pready = 1'b1;
            nxt_st.pslverr = ~mapped;
            nxt_st.prdata = pwrite ? 32'h0000_0000 : rd_val;
        end
        if (acc_done) begin
            nxt_st.pready = 1'b0;
            nxt_st.pslverr = 1'b0;
        end
        if (vec_ack_first) begin
            nxt_st.ovf_first = 1'b0;
        end
        if (vec_ack_second) begin
            nxt_st.ovf_second = 1'b0;
        end
        if (wr_en && dtm_idx_hit(paddr, IDX_CTRL)) begin
            nxt_st.ovf_second = pwdata[CTL_OVF_SECOND];
            nxt_st.run_second = pwdata[CTL_RUN_SECOND];
            nxt_st.ovf_first = pwdata[CTL_OVF_FIRST];
            nxt_st.run_first = pwdata[CTL_RUN_FIRST];
        end
        if (wr_en && dtm_idx_hit(paddr, IDX_MODE)) begin
            nxt_st.mode = pwdata[7:0];
        end
        if (wr_en && dtm_idx_hit(paddr, IDX_INT_ENABLE)) begin
            nxt_st.int_enable = pwdata[1:0];
        end
        if (wr_en && dtm_idx_hit(paddr, IDX_INT_CLEAR)) begin
            nxt_st.int_status = st_ff.int_status & ~pwdata[1:0];
        end
        // hardware set comes last so an event never loses to a clear
        if (evt_first) begin
            nxt_st.ovf_first = 1'b1;
            nxt_st.int_status[INT_FIRST] = 1'b1;
        end
        if (evt_second) begin
            nxt_st.ovf_second = 1'b1;
            nxt_st.int_status[INT_SECOND] = 1'b1;
        end
        nxt_st.irq = |(nxt_st.int_status & nxt_st.int_enable);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.mode <= RST_MODE;
            st_ff.int_status <= RST_INT;
            st_ff.int_enable <= RST_INT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign irq = st_ff.irq;
    assign overflow_flag_first = st_ff.ovf_first;
    assign overflow_flag_second = st_ff.ovf_second;

    a_flag_set: assert property (
        @(posedge core_clk) disable iff (rst)
        ovf_evt_first |=> overflow_flag_first && st_ff.int_status[INT_FIRST])
        else $error("first overflow flag not set");

    a_flag_ack: assert property (
        @(posedge core_clk) disable iff (rst)
        (vec_ack_second && !evt_second &&
         !(wr_en && dtm_idx_hit(paddr, IDX_CTRL)))
        |=> !overflow_flag_second)
        else $error("vector acknowledge did not clear flag");

    a_split_flag: assert property (
        @(posedge core_clk) disable iff (rst)
        (split_first && ovf_evt_split) |=> overflow_flag_second)
        else $error("split high overflow missed second flag");

    a_run_start: assert property (
        @(posedge core_clk) disable iff (rst)
        (wr_en && dtm_idx_hit(paddr, IDX_CTRL))
        |=> st_ff.run_first == $past(pwdata[CTL_RUN_FIRST]))
        else $error("run bit write not taken");

    a_irq_level: assert property (
        @(posedge core_clk) disable iff (rst)
        ##1 irq == |(st_ff.int_status & st_ff.int_enable))
        else $error("interrupt output disagrees with status");

endmodule // dtm_timer_pair

/* File: dtm_timer_pair_tb_top.sv */
`timescale 1ns/1ps
module dtm_timer_pair_tb_top import dtm_pkg::*;;
    logic core_clk, rst, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, irq, overflow_flag_first, overflow_flag_second;
    logic vec_ack_first, vec_ack_second, gate_req_first, gate_req_second;
    logic [3:0] pstrb;
    logic evt_req_first, evt_req_second;
    logic ext_irq_pin_first, ext_irq_pin_second;
    logic event_input_first, event_input_second;
    logic [7:0] rd;
    logic err;
    int bad_count, cmp_count;
    logic [7:0] regs [9] = '{IDX_CTRL, IDX_MODE, IDX_CNT_LO_FIRST,
        IDX_CNT_LO_SECOND, IDX_CNT_HI_FIRST, IDX_CNT_HI_SECOND,
        IDX_INT_STATUS, IDX_INT_ENABLE, IDX_INT_CLEAR};

    dtm_timer_pair dtm_timer_pair_inst (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq_pin_first(ext_irq_pin_first),
        .ext_irq_pin_second(ext_irq_pin_second),
        .event_input_first(event_input_first),
        .event_input_second(event_input_second),
        .vec_ack_first(vec_ack_first),
        .vec_ack_second(vec_ack_second), .irq(irq),
        .overflow_flag_first(overflow_flag_first),
        .overflow_flag_second(overflow_flag_second)
    );

    dtm_pin_model dtm_pin_model_inst (
        .core_clk(core_clk), .rst(rst),
        .gate_req_first(gate_req_first), .gate_req_second(gate_req_second),
        .evt_req_first(evt_req_first), .evt_req_second(evt_req_second),
        .ext_irq_pin_first(ext_irq_pin_first),
        .ext_irq_pin_second(ext_irq_pin_second),
        .event_input_first(event_input_first),
        .event_input_second(event_input_second)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [8:0] seen,
                         input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk1(input string what, input logic seen,
                        input logic exp);
        check(what, {8'h00, seen}, {8'h00, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // values read right after the edge are those the edge sampled
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata[7:0];
        err = pslverr;
        if (pready !== 1'b1) begin
            bad_count++;
            $display("Error pready expected 1 seen %b", pready);
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never re-drives psel at once
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        apb(1'b1, idx, v);
    endtask

    task automatic rchk(input string what, input logic [7:0] idx,
                        input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(what, {err, rd}, {1'b0, exp});
    endtask

    task automatic gpulse(input int n);
        gate_req_first <= 1'b1;
        cyc(n);
        gate_req_first <= 1'b0;
        cyc(4);
    endtask

    task automatic events(input bit second, input int n);
        if (second) begin
            evt_req_second <= 1'b1;
        end else begin
            evt_req_first <= 1'b1;
        end
        cyc(2 * n);
        evt_req_first <= 1'b0;
        evt_req_second <= 1'b0;
        cyc(4);
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        vec_ack_first = 1'b0;
        vec_ack_second = 1'b0;
        pstrb = 4'hF;
        gate_req_first = 1'b0;
        gate_req_second = 1'b0;
        evt_req_first = 1'b0;
        evt_req_second = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        cyc(5);
        rst <= 1'b0;
        cyc(1);
        foreach (regs[i]) begin
            rchk("reset value", regs[i], RST_CTRL);
        end
        wr(IDX_INT_STATUS, 8'hFF);
        rchk("status read only", IDX_INT_STATUS, 8'h00);
        apb(1'b0, 8'h93, 8'h00);
        chk1("unmapped slverr", err, 1'b1);
        // gated first timer, 16-bit cascade
        wr(IDX_MODE, 8'h09);
        wr(IDX_CNT_LO_FIRST, 8'hFC);
        wr(IDX_CNT_HI_FIRST, 8'h12);
        wr(IDX_CTRL, 8'h10);
        cyc(10);
        rchk("gated low", IDX_CNT_LO_FIRST, 8'hFC);
        gpulse(6);
        rchk("cascade low", IDX_CNT_LO_FIRST, 8'h02);
        rchk("cascade high", IDX_CNT_HI_FIRST, 8'h13);
        wr(IDX_CTRL, 8'h00);
        gpulse(5);
        rchk("stopped low", IDX_CNT_LO_FIRST, 8'h02);
        // prescale mode: only low five bits count
        wr(IDX_MODE, 8'h08);
        wr(IDX_CNT_LO_FIRST, 8'hFE);
        wr(IDX_CNT_HI_FIRST, 8'h05);
        wr(IDX_CTRL, 8'h10);
        gpulse(3);
        rchk("prescale low", IDX_CNT_LO_FIRST, 8'hE1);
        rchk("prescale high", IDX_CNT_HI_FIRST, 8'h06);
        // auto-reload with overflow and interrupt
        wr(IDX_MODE, 8'h0A);
        wr(IDX_CNT_HI_FIRST, 8'h80);
        wr(IDX_CNT_LO_FIRST, 8'hFE);
        gpulse(4);
        rchk("reload low", IDX_CNT_LO_FIRST, 8'h82);
        rchk("reload high", IDX_CNT_HI_FIRST, 8'h80);
        rchk("control flag", IDX_CTRL, 8'h30);
        chk1("flag first", overflow_flag_first, 1'b1);
        rchk("status", IDX_INT_STATUS, 8'h01);
        chk1("irq masked", irq, 1'b0);
        wr(IDX_INT_ENABLE, 8'h01);
        cyc(1);
        chk1("irq raised", irq, 1'b1);
        vec_ack_first <= 1'b1;
        cyc(1);
        vec_ack_first <= 1'b0;
        cyc(2);
        chk1("flag cleared", overflow_flag_first, 1'b0);
        chk1("irq held", irq, 1'b1);
        wr(IDX_INT_CLEAR, 8'h01);
        cyc(2);
        chk1("irq cleared", irq, 1'b0);
        // low byte lane off: the write must be dropped
        pstrb <= 4'hE;
        wr(IDX_INT_ENABLE, 8'h03);
        pstrb <= 4'hF;
        rchk("strobe off", IDX_INT_ENABLE, 8'h01);
        // second timer as event counter
        wr(IDX_CTRL, 8'h00);
        wr(IDX_MODE, 8'h50);
        wr(IDX_CNT_LO_SECOND, 8'h00);
        wr(IDX_CNT_HI_SECOND, 8'h00);
        wr(IDX_CTRL, 8'h40);
        events(1'b1, 5);
        rchk("events ungated", IDX_CNT_LO_SECOND, 8'h05);
        wr(IDX_MODE, 8'hD0);
        events(1'b1, 3);
        rchk("events pin low", IDX_CNT_LO_SECOND, 8'h05);
        gate_req_second <= 1'b1;
        cyc(3);
        events(1'b1, 3);
        gate_req_second <= 1'b0;
        rchk("events pin high", IDX_CNT_LO_SECOND, 8'h08);
        // second timer stopped in mode 11
        wr(IDX_MODE, 8'h30);
        cyc(10);
        rchk("mode 11 hold", IDX_CNT_LO_SECOND, 8'h08);
        // split mode: low byte counts events, high byte free runs
        wr(IDX_CTRL, 8'h00);
        wr(IDX_CNT_LO_FIRST, 8'h00);
        wr(IDX_CNT_HI_FIRST, 8'hF0);
        wr(IDX_MODE, 8'h3F);
        wr(IDX_CTRL, 8'h50);
        gate_req_first <= 1'b1;
        cyc(2);
        events(1'b0, 4);
        gate_req_first <= 1'b0;
        cyc(4);
        rchk("split low", IDX_CNT_LO_FIRST, 8'h04);
        chk1("split flag", overflow_flag_second, 1'b1);
        chk1("split first flag", overflow_flag_first, 1'b0);
        rchk("split status", IDX_INT_STATUS, 8'h02);
        chk1("irq mask second", irq, 1'b0);
        // stop the split byte but keep the second flag set by software
        wr(IDX_CTRL, 8'h80);
        chk1("flag kept", overflow_flag_second, 1'b1);
        vec_ack_second <= 1'b1;
        cyc(1);
        vec_ack_second <= 1'b0;
        cyc(2);
        chk1("ack second", overflow_flag_second, 1'b0);
        tally_and_finish();
    end
endmodule // dtm_timer_pair_tb_top

/* File: dtm_timer_unit.sv */
`timescale 1ns/1ps
module dtm_timer_unit
    import dtm_pkg::*;
#(
    parameter bit HAS_SPLIT = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] mode_sel,
    input wire logic count_src,
    input wire logic gate,
    input wire logic run,
    input wire logic ext_irq_pin,
    input wire logic event_fall,
    input wire logic split_run,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    output logic [7:0] count_lo,
    output logic [7:0] count_hi,
    output logic ovf,
    output logic ovf_hi
);
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic ovf;
        logic ovf_hi;
    } dtm_unit_st_t;

    dtm_unit_st_t st_ff;
    dtm_unit_st_t nxt_st;
    logic en;
    logic inc;
    logic no_wr;

    assign en = run & (~gate | ext_irq_pin);
    assign inc = en & (count_src ? event_fall : 1'b1);
    assign no_wr = ~wr_lo & ~wr_hi;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ovf = 1'b0;
        nxt_st.ovf_hi = 1'b0;
        case (mode_sel)
            MODE_PRESCALE: begin
                // upper three low-byte bits are left as software wrote them
                if (inc) begin
                    nxt_st.lo[4:0] = st_ff.lo[4:0] + 5'h01;
                    if (st_ff.lo[4:0] == PRESC_MAX) begin
                        nxt_st.hi = st_ff.hi + 8'h01;
                        nxt_st.ovf = (st_ff.hi == BYTE_MAX);
                    end
                end
            end
            MODE_FULL: begin
                if (inc) begin
                    {nxt_st.hi, nxt_st.lo} =
                        {st_ff.hi, st_ff.lo} + 16'h0001;
                    nxt_st.ovf = (st_ff.hi == BYTE_MAX) &&
                                 (st_ff.lo == BYTE_MAX);
                end
            end
            MODE_RELOAD: begin
                if (inc) begin
                    if (st_ff.lo == BYTE_MAX) begin
                        nxt_st.lo = st_ff.hi;
                        nxt_st.ovf = 1'b1;
                    end else begin
                        nxt_st.lo = st_ff.lo + 8'h01;
                    end
                end
            end
            MODE_SPLIT: begin
                // the second timer has no split mode: it just holds
                if (HAS_SPLIT) begin
                    if (inc) begin
                        nxt_st.lo = st_ff.lo + 8'h01;
                        nxt_st.ovf = (st_ff.lo == BYTE_MAX);
                    end
                    if (split_run) begin
                        nxt_st.hi = st_ff.hi + 8'h01;
                        nxt_st.ovf_hi = (st_ff.hi == BYTE_MAX);
                    end
                end
            end
            default: begin
            end
        endcase
        // a software write to a byte beats the count on that byte
        if (wr_lo) begin
            nxt_st.lo = wdata;
        end
        if (wr_hi) begin
            nxt_st.hi = wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff <= {RST_COUNT, RST_COUNT, 1'b0, 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign count_lo = st_ff.lo;
    assign count_hi = st_ff.hi;
    assign ovf = st_ff.ovf;
    assign ovf_hi = st_ff.ovf_hi;

    a_gate_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        (gate && !ext_irq_pin && no_wr && mode_sel != MODE_SPLIT)
        |=> $stable(count_lo) && $stable(count_hi))
        else $error("gated timer advanced while pin low");

    a_run_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        (!run && !wr_lo) |=> $stable(count_lo))
        else $error("low byte advanced with run bit clear");

    a_full_inc: assert property (
        @(posedge core_clk) disable iff (rst)
        (mode_sel == MODE_FULL && en && !count_src && no_wr)
        |=> {count_hi, count_lo} == $past({count_hi, count_lo}) + 16'h0001)
        else $error("16-bit timer did not step by one");

    a_presc_wrap: assert property (
        @(posedge core_clk) disable iff (rst)
        (mode_sel == MODE_PRESCALE && inc && no_wr &&
         count_lo[4:0] == PRESC_MAX)
        |=> count_lo[4:0] == 5'h00 && count_hi == $past(count_hi) + 8'h01)
        else $error("prescaler wrap did not step high byte");

    a_auto_reload: assert property (
        @(posedge core_clk) disable iff (rst)
        (mode_sel == MODE_RELOAD && inc && no_wr && count_lo == BYTE_MAX)
        |=> count_lo == $past(count_hi) && ovf)
        else $error("low byte not reloaded from high byte");

    a_event_src: assert property (
        @(posedge core_clk) disable iff (rst)
        (count_src && !event_fall && no_wr && mode_sel != MODE_SPLIT)
        |=> $stable(count_lo))
        else $error("counter advanced without input event");

    a_stopped: assert property (
        @(posedge core_clk) disable iff (rst)
        (!HAS_SPLIT && mode_sel == MODE_SPLIT && no_wr) [*2]
        |-> $stable(count_lo) && $stable(count_hi) && !ovf)
        else $error("stopped timer changed");

    a_split_high: assert property (
        @(posedge core_clk) disable iff (rst)
        (HAS_SPLIT && mode_sel == MODE_SPLIT && split_run && !wr_hi)
        |=> count_hi == $past(count_hi) + 8'h01)
        else $error("split high byte did not step");

endmodule // dtm_timer_unit
